// >>> verilog/cscm_pkg.sv
// Constants shared by the CAN status and configuration command map
package cscm_pkg;
  localparam int ID_W     = 29;
  localparam int DLC_W    = 4;
  localparam int DATA_W   = 64;
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 3;
  localparam int RSP_W    = 48;
  localparam int LEN_W    = 3;
  localparam int SCALE_W  = 4;
  localparam int SCALE_N  = 6;
  localparam int SCALE_B  = SCALE_W * SCALE_N;
  localparam int ANA_W    = 16;
  // Identifier layout: upper 21 bits fixed, low byte is the unit address
  localparam logic [20:0] ID_RX_HI   = 21'h000c03;
  localparam logic [20:0] ID_TX_HI   = 21'h000c02;
  localparam logic [7:0]  BCAST_ADDR = 8'hff;
  // Command codes
  localparam logic [15:0] CMD_OPERATION = 16'h0000;
  localparam logic [15:0] CMD_OUTPUT_VOLTAGE_SETPOINT  = 16'h0020;
  localparam logic [15:0] CMD_OUTPUT_CURRENT_SETPOINT  = 16'h0030;
  localparam logic [15:0] CMD_SCALING   = 16'h00c0;
  localparam logic [15:0] CMD_STATUS    = 16'h00c1;
  localparam logic [15:0] CMD_CONFIG    = 16'h00c2;
  localparam logic [15:0] CMD_BIDIR     = 16'h0140;
  // Frame lengths
  localparam logic [3:0] DLC_WRITE = 4'h4;
  localparam logic [3:0] DLC_READ  = 4'h2;
  localparam logic [3:0] DLC_HDR   = 4'h2;
  localparam logic [2:0] LEN_OP    = 3'h1;
  localparam logic [2:0] LEN_WORD  = 3'h2;
  localparam logic [2:0] LEN_SCALE = 3'h6;
  // Status word bit positions
  localparam int ST_MASTER   = 0;
  localparam int ST_SECONDARY_OUTPUT_GOOD    = 1;
  localparam int ST_PRIMARY_STAGE_GOOD   = 2;
  localparam int ST_DUMMY    = 4;
  localparam int ST_INIT     = 5;
  localparam int ST_NVM_ERR  = 6;
  // Configuration fields
  localparam int CFG_CAN_CTRL = 0;
  localparam int CFG_PRE_LO   = 1;
  localparam int CFG_PRE_HI   = 2;
  localparam int BIDIR_MODE   = 0;
  localparam logic [15:0] CFG_MASK   = 16'h0007;
  localparam logic [15:0] BIDIR_MASK = 16'h0001;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [15:0] BIDIR_RST  = 16'h0000;
  localparam logic [15:0] SET_RST    = 16'h0000;
  localparam logic [1:0]  PRESET_OFF  = 2'h0;
  localparam logic [1:0]  PRESET_ON   = 2'h1;
  localparam logic [1:0]  PRESET_KEEP = 2'h2;
  localparam logic [7:0]  OP_OFF = 8'h00;
  localparam logic [7:0]  OP_ON  = 8'h01;
  // Scaling codes
  localparam logic [3:0] SCALE_NONE = 4'h0;
  localparam logic [3:0] SCALE_MIN  = 4'h4;
  localparam logic [3:0] SCALE_MAX  = 4'h9;
endpackage

// >>> verilog/cscm_cmd_if.sv
// Command and response carrier between frame parser, core and sender
interface cscm_cmd_if;
  logic        cmd_valid;
  logic        cmd_write;
  logic [15:0] cmd_code;
  logic [15:0] cmd_value;
  logic        rsp_valid;
  logic [15:0] rsp_code;
  logic [2:0]  rsp_len;
  logic [47:0] rsp_data;
  logic        tx_busy;
  modport rx   (output cmd_valid, cmd_write, cmd_code, cmd_value);
  modport core (input cmd_valid, cmd_write, cmd_code, cmd_value, tx_busy,
                output rsp_valid, rsp_code, rsp_len, rsp_data);
  modport tx   (input rsp_valid, rsp_code, rsp_len, rsp_data,
                output tx_busy);
endinterface

// >>> verilog/cscm_frame_rx.sv
// Frame filter and decoder for controller-to-unit frames
module cscm_frame_rx (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          rx_valid_i,
  input  wire logic [cscm_pkg::ID_W-1:0]     rx_id_i,
  input  wire logic [cscm_pkg::DLC_W-1:0]    rx_dlc_i,
  input  wire logic [cscm_pkg::DATA_W-1:0]   rx_data_i,
  input  wire logic [cscm_pkg::ADDR_W-1:0]   addr_i,
  cscm_cmd_if.rx                             bus
);
  import cscm_pkg::*;
  logic hi_ok, mine, bcast, is_wr, is_rd;
  assign hi_ok = rx_id_i[ID_W-1:8] == ID_RX_HI;
  assign mine  = hi_ok && rx_id_i[7:0] == {5'h00, addr_i};
  assign bcast = hi_ok && rx_id_i[7:0] == BCAST_ADDR;
  assign is_wr = rx_dlc_i == DLC_WRITE && (mine || bcast);
  // A broadcast read would make every unit answer at once
  assign is_rd = rx_dlc_i == DLC_READ && mine;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.cmd_valid <= 1'b0;
      bus.cmd_write <= 1'b0;
      bus.cmd_code  <= 16'h0000;
      bus.cmd_value <= 16'h0000;
    end else begin
      bus.cmd_valid <= rx_valid_i && (is_wr || is_rd);
      bus.cmd_write <= is_wr;
      bus.cmd_code  <= {rx_data_i[15:8], rx_data_i[7:0]};
      bus.cmd_value <= {rx_data_i[31:24], rx_data_i[23:16]};
    end
  end
endmodule // cscm_frame_rx

// >>> verilog/cscm_frame_tx.sv
// Holds one answer frame until the CAN controller takes it
module cscm_frame_tx (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [cscm_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic                          tx_ready_i,
  output logic                               tx_valid_o,
  output logic [cscm_pkg::ID_W-1:0]          tx_id_o,
  output logic [cscm_pkg::DLC_W-1:0]         tx_dlc_o,
  output logic [cscm_pkg::DATA_W-1:0]        tx_data_o,
  cscm_cmd_if.tx                             bus
);
  import cscm_pkg::*;
  typedef enum logic {CSCM_IDLE, CSCM_SEND} cscm_tx_e;
  cscm_tx_e state;
  assign bus.tx_busy = state == CSCM_SEND;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= CSCM_IDLE;
      tx_valid_o <= 1'b0;
      tx_id_o    <= '0;
      tx_dlc_o   <= '0;
      tx_data_o  <= '0;
    end else begin
      case (state)
        CSCM_IDLE: begin
          if (bus.rsp_valid) begin
            state      <= CSCM_SEND;
            tx_valid_o <= 1'b1;
            tx_id_o    <= {ID_TX_HI, 5'h00, addr_i};
            tx_dlc_o   <= DLC_HDR + {1'b0, bus.rsp_len};
            tx_data_o  <= {bus.rsp_data, bus.rsp_code[15:8],
                           bus.rsp_code[7:0]};
          end
        end
        CSCM_SEND: begin
          if (tx_ready_i) begin
            state      <= CSCM_IDLE;
            tx_valid_o <= 1'b0;
          end
        end
        default: state <= CSCM_IDLE;
      endcase
    end
  end
endmodule // cscm_frame_tx

// >>> verilog/cscm_status_config.sv
// Top of the CAN status and configuration command map
//
// How it works
// - Scaling byte 1 low nibble: AC voltage code; 0 none, 4-9 decades.
// - Scaling byte 1 high nibble reports fan speed code, same code set.
// - Scaling byte 2 low nibble reports ambient temperature code.
// - Scaling byte 3 low nibble: AC current; codes A-F never reported.
// - Status bit 0 is one when this unit is parallel master.
// - Status bit 1 is one while secondary output voltage is normal.
// - Status bit 2 is one while the primary stage runs normally.
// - Status bit 4 is one while the dummy load is on.
// - Status bit 5 is zero while initialising, one once finished.
// - Status bit 6: memory error; unit off and dark until it clears.
// - Config bit 0 picks local adjuster or CAN setpoints and on/off.
// - Config bits 2:1 set power-up operation: off, on, keep, reserved.
// - Mode bit 0: auto-detect ignores direction inputs, battery uses them.
// - Read frame: length 2 with code; answer repeats code then value.
// - Unit answers on 0x000C02xx, listens on 0x000C03xx and, for writes only, on broadcast 0xFF.
module cscm_status_config (
  input  wire logic                          CLOCK_I,
  input  wire logic                          RSTN_I,
  input  wire logic [cscm_pkg::ADDR_W-1:0]   UNIT_ADDR_I,
  input  wire logic                          RX_VALID_I,
  input  wire logic [cscm_pkg::ID_W-1:0]     RX_ID_I,
  input  wire logic [cscm_pkg::DLC_W-1:0]    RX_DLC_I,
  input  wire logic [cscm_pkg::DATA_W-1:0]   RX_DATA_I,
  input  wire logic                          TX_READY_I,
  input  wire logic                          PAR_MASTER_I,
  input  wire logic                          SECONDARY_OUTPUT_GOOD_I,
  input  wire logic                          PRIMARY_STAGE_GOOD_I,
  input  wire logic                          DUMMY_LOAD_ACTIVE_I,
  input  wire logic                          INIT_DONE_I,
  input  wire logic                          NVM_ACCESS_ERROR_I,
  input  wire logic [cscm_pkg::SCALE_B-1:0]  SCALE_CODES_I,
  input  wire logic [2:0]                    CFG_STORED_I,
  input  wire logic                          BIDIR_STORED_I,
  input  wire logic                          OP_STORED_I,
  input  wire logic [cscm_pkg::WORD_W-1:0]   LOCAL_ADJUSTER_VOUT_I,
  input  wire logic [cscm_pkg::WORD_W-1:0]   LOCAL_ADJUSTER_IOUT_I,
  input  wire logic                          LOCAL_ON_I,
  input  wire logic                          DIR_CTRL_I,
  input  wire logic [cscm_pkg::ANA_W-1:0]    CD_CTRL_I,
  output logic                               TX_VALID_O,
  output logic [cscm_pkg::ID_W-1:0]          TX_ID_O,
  output logic [cscm_pkg::DLC_W-1:0]         TX_DLC_O,
  output logic [cscm_pkg::DATA_W-1:0]        TX_DATA_O,
  output logic [cscm_pkg::WORD_W-1:0]        VOUT_TARGET_O,
  output logic [cscm_pkg::WORD_W-1:0]        IOUT_TARGET_O,
  output logic                               OUTPUT_ON_O,
  output logic                               SHUTDOWN_O,
  output logic                               LED_ON_O,
  output logic                               CAN_CTRL_O,
  output logic                               BATTERY_MODE_O,
  output logic                               DIR_CTRL_EFF_O,
  output logic [cscm_pkg::ANA_W-1:0]         CD_CTRL_EFF_O
);
  import cscm_pkg::*;

  logic               rst_meta;
  logic               rst_n;
  logic               loaded;
  logic [WORD_W-1:0]  sys_config;
  logic [WORD_W-1:0]  bidirectional_mode_config;
  logic [7:0]         operation;
  logic [WORD_W-1:0]  output_voltage_setpoint;
  logic [WORD_W-1:0]  output_current_setpoint;
  logic [WORD_W-1:0]  sys_status;
  logic [WORD_W-1:0]  next_status;
  logic [SCALE_B-1:0] scale_q;
  logic [RSP_W-1:0]   scale_word;
  logic               write_ok;
  logic               read_ok;
  logic               rd_known;
  logic [LEN_W-1:0]   rd_len;
  logic [RSP_W-1:0]   rd_data;
  logic               can_ctrl;
  logic               batt_mode;

  cscm_cmd_if bus ();

  // Reset release through two flops
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  cscm_frame_rx u_rx (
    .clk_i      (CLOCK_I),
    .rst_n_i    (rst_n),
    .rx_valid_i (RX_VALID_I),
    .rx_id_i    (RX_ID_I),
    .rx_dlc_i   (RX_DLC_I),
    .rx_data_i  (RX_DATA_I),
    .addr_i     (UNIT_ADDR_I),
    .bus        (bus.rx)
  );

  cscm_frame_tx u_tx (
    .clk_i      (CLOCK_I),
    .rst_n_i    (rst_n),
    .addr_i     (UNIT_ADDR_I),
    .tx_ready_i (TX_READY_I),
    .tx_valid_o (TX_VALID_O),
    .tx_id_o    (TX_ID_O),
    .tx_dlc_o   (TX_DLC_O),
    .tx_data_o  (TX_DATA_O),
    .bus        (bus.tx)
  );

  assign can_ctrl  = sys_config[CFG_CAN_CTRL];
  assign batt_mode = bidirectional_mode_config[BIDIR_MODE];
  assign write_ok  = bus.cmd_valid && bus.cmd_write && loaded;
  // One answer in flight at a time; later reads are dropped
  assign read_ok   = bus.cmd_valid && !bus.cmd_write && loaded
                     && !bus.tx_busy && !bus.rsp_valid;

  // Stored settings are taken one cycle after reset release
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      sys_config <= CFG_RST;
    end else if (!loaded) begin
      sys_config <= {13'h0000, CFG_STORED_I};
    end else if (write_ok && bus.cmd_code == CMD_CONFIG) begin
      sys_config <= bus.cmd_value & CFG_MASK;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      bidirectional_mode_config <= BIDIR_RST;
    end else if (!loaded) begin
      bidirectional_mode_config <= {15'h0000, BIDIR_STORED_I};
    end else if (write_ok && bus.cmd_code == CMD_BIDIR) begin
      bidirectional_mode_config <= bus.cmd_value & BIDIR_MASK;
    end
  end

  // Power-up operation value from the stored preset field
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      operation <= OP_OFF;
    end else if (!loaded) begin
      case (CFG_STORED_I[CFG_PRE_HI:CFG_PRE_LO])
        PRESET_ON:   operation <= OP_ON;
        PRESET_KEEP: operation <= {7'h00, OP_STORED_I};
        default:     operation <= OP_OFF;
      endcase
    end else if (write_ok && bus.cmd_code == CMD_OPERATION
                 && bus.cmd_value[15:1] == 15'h0000) begin
      operation <= bus.cmd_value[7:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      output_voltage_setpoint <= SET_RST;
      output_current_setpoint <= SET_RST;
    end else if (write_ok) begin
      if (bus.cmd_code == CMD_OUTPUT_VOLTAGE_SETPOINT) begin
        output_voltage_setpoint <= bus.cmd_value;
      end
      if (bus.cmd_code == CMD_OUTPUT_CURRENT_SETPOINT) begin
        output_current_setpoint <= bus.cmd_value;
      end
    end
  end

  // Only legal decade codes are reported; anything else reads unsupported
  genvar gi;
  generate
    for (gi = 0; gi < SCALE_N; gi++) begin : g_scale
      always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
          scale_q[gi*SCALE_W +: SCALE_W] <= SCALE_NONE;
        end else if (SCALE_CODES_I[gi*SCALE_W +: SCALE_W] >= SCALE_MIN
                  && SCALE_CODES_I[gi*SCALE_W +: SCALE_W] <= SCALE_MAX)
        begin
          scale_q[gi*SCALE_W +: SCALE_W] <=
            SCALE_CODES_I[gi*SCALE_W +: SCALE_W];
        end else begin
          scale_q[gi*SCALE_W +: SCALE_W] <= SCALE_NONE;
        end
      end
    end
  endgenerate

  // Bytes 0-1 carry dc and ac/fan codes packed, bytes 2-3 one code each
  assign scale_word = {16'h0000,
                       4'h0, scale_q[23:20],
                       4'h0, scale_q[19:16],
                       scale_q[15:12], scale_q[11:8],
                       scale_q[7:0]};

  always_comb begin
    next_status             = '0;
    next_status[ST_MASTER]  = PAR_MASTER_I;
    next_status[ST_SECONDARY_OUTPUT_GOOD]   = SECONDARY_OUTPUT_GOOD_I;
    next_status[ST_PRIMARY_STAGE_GOOD]  = PRIMARY_STAGE_GOOD_I;
    next_status[ST_DUMMY]   = DUMMY_LOAD_ACTIVE_I;
    next_status[ST_INIT]    = INIT_DONE_I;
    next_status[ST_NVM_ERR] = NVM_ACCESS_ERROR_I;
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      sys_status <= '0;
    end else begin
      sys_status <= next_status;
    end
  end

  // Read answer selection
  always_comb begin
    rd_known = 1'b1;
    rd_len   = LEN_WORD;
    rd_data  = '0;
    case (bus.cmd_code)
      CMD_OPERATION: begin
        rd_len  = LEN_OP;
        rd_data = {40'h0, operation};
      end
      CMD_OUTPUT_VOLTAGE_SETPOINT: rd_data = {32'h0, output_voltage_setpoint};
      CMD_OUTPUT_CURRENT_SETPOINT: rd_data = {32'h0, output_current_setpoint};
      CMD_SCALING: begin
        rd_len  = LEN_SCALE;
        rd_data = scale_word;
      end
      CMD_STATUS: rd_data = {32'h0, sys_status};
      CMD_CONFIG: rd_data = {32'h0, sys_config};
      CMD_BIDIR:  rd_data = {32'h0, bidirectional_mode_config};
      default:    rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      bus.rsp_valid <= 1'b0;
      bus.rsp_code  <= 16'h0000;
      bus.rsp_len   <= '0;
      bus.rsp_data  <= '0;
    end else begin
      bus.rsp_valid <= read_ok && rd_known;
      if (read_ok) begin
        bus.rsp_code <= bus.cmd_code;
        bus.rsp_len  <= rd_len;
        bus.rsp_data <= rd_data;
      end
    end
  end

  // Setpoint source and output enable
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      VOUT_TARGET_O <= SET_RST;
      IOUT_TARGET_O <= SET_RST;
      OUTPUT_ON_O   <= 1'b0;
      CAN_CTRL_O    <= 1'b0;
    end else begin
      VOUT_TARGET_O <= can_ctrl ? output_voltage_setpoint : LOCAL_ADJUSTER_VOUT_I;
      IOUT_TARGET_O <= can_ctrl ? output_current_setpoint : LOCAL_ADJUSTER_IOUT_I;
      OUTPUT_ON_O   <= loaded && !NVM_ACCESS_ERROR_I
                       && (can_ctrl ? operation == OP_ON : LOCAL_ON_I);
      CAN_CTRL_O    <= can_ctrl;
    end
  end

  // Memory error holds the unit off only while the error persists
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      SHUTDOWN_O <= 1'b0;
      LED_ON_O   <= 1'b0;
    end else begin
      SHUTDOWN_O <= NVM_ACCESS_ERROR_I;
      LED_ON_O   <= !NVM_ACCESS_ERROR_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      BATTERY_MODE_O <= 1'b0;
      DIR_CTRL_EFF_O <= 1'b0;
      CD_CTRL_EFF_O  <= '0;
    end else begin
      BATTERY_MODE_O <= batt_mode;
      DIR_CTRL_EFF_O <= batt_mode && DIR_CTRL_I;
      CD_CTRL_EFF_O  <= batt_mode ? CD_CTRL_I : '0;
    end
  end

  a_status_map: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    $past(loaded) |-> sys_status ==
      {9'h000, $past(NVM_ACCESS_ERROR_I), $past(INIT_DONE_I),
       $past(DUMMY_LOAD_ACTIVE_I), 1'b0, $past(PRIMARY_STAGE_GOOD_I),
       $past(SECONDARY_OUTPUT_GOOD_I), $past(PAR_MASTER_I)})
    else $error("status word does not follow its sources");

  a_nvm_off: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    NVM_ACCESS_ERROR_I |=> !OUTPUT_ON_O && !LED_ON_O && SHUTDOWN_O)
    else $error("memory error did not shut the unit down");

  a_nvm_recover: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    $fell(NVM_ACCESS_ERROR_I) |=> LED_ON_O && !SHUTDOWN_O)
    else $error("unit did not recover after memory error");

  a_scale_legal: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    $past(SCALE_CODES_I[23:20]) > SCALE_MAX
      |-> scale_word[27:24] == SCALE_NONE
          && scale_word[31:28] == 4'h0)
    else $error("illegal scaling code reported");

  a_scale_acv: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    ##1 ($past(SCALE_CODES_I[11:8]) == SCALE_MAX) |->
      scale_word[11:8] == SCALE_MAX)
    else $error("AC voltage code lost");

  a_undef_zero: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (sys_config & ~CFG_MASK) == 16'h0000
    && (bidirectional_mode_config & ~BIDIR_MASK) == 16'h0000
    && sys_status[3] == 1'b0 && sys_status[15:7] == 9'h000)
    else $error("undefined bit reads non-zero");

  a_cfg_write: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    write_ok && bus.cmd_code == CMD_CONFIG |=>
      sys_config == ($past(bus.cmd_value) & CFG_MASK))
    else $error("configuration write not taken");

  a_local_src: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    rst_n && !can_ctrl |=> VOUT_TARGET_O == $past(LOCAL_ADJUSTER_VOUT_I))
    else $error("local adjuster not in control");

  a_bidir_gate: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    !batt_mode |=> !DIR_CTRL_EFF_O && CD_CTRL_EFF_O == '0)
    else $error("direction inputs used in auto-detect mode");

  a_preset_on: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    rst_n && !loaded && CFG_STORED_I[2:1] == PRESET_ON |=> operation == OP_ON)
    else $error("power-up preset on not applied");

  a_read_reply: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    read_ok && bus.cmd_code == CMD_STATUS |=> ##1
      TX_VALID_O && TX_DLC_O == 4'h4
      && TX_DATA_O[15:0] == CMD_STATUS
      && TX_ID_O == {ID_TX_HI, 5'h00, UNIT_ADDR_I})
    else $error("status read not answered in two cycles");
endmodule // cscm_status_config

// >>> verif/cscm_ctrl_model.sv
// External CAN controller model: sends frames, takes answers
module cscm_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        tx_valid_i,
  input  wire logic [28:0] tx_id_i,
  input  wire logic [3:0]  tx_dlc_i,
  input  wire logic [63:0] tx_data_i,
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic [28:0]      rx_id_o,
  output logic [3:0]       rx_dlc_o,
  output logic [63:0]      rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          stall = 2;
  int          wait_n = 0;
  int          n_got = 0;
  logic [28:0] got_id;
  logic [3:0]  got_dlc;
  logic [63:0] got_data;
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_id_o = '0;
    rx_dlc_o = '0;
    rx_data_o = '0;
  end
  // Fields hold only for the pulse, then junk so nothing leans on them
  task automatic send(input logic [28:0] id, input logic [3:0] dlc,
                      input logic [63:0] data);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_id_o = id;
    rx_dlc_o = dlc;
    rx_data_o = data;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_id_o = ~id;
    rx_dlc_o = ~dlc;
    rx_data_o = ~data;
  endtask
  // Slow acceptance makes the sender hold its frame
  always @(negedge clk_i) begin
    wait_n <= tx_valid_i ? wait_n + 1 : 0;
    tx_ready_o <= tx_valid_i && wait_n >= stall;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      n_got <= n_got + 1;
      got_id <= tx_id_i;
      got_dlc <= tx_dlc_i;
      got_data <= tx_data_i;
    end
  end
endmodule // cscm_ctrl_model

// >>> verif/tb_cscm_status_config.sv
// Self-checking bench for the status and configuration command map
module tb_cscm_status_config;
  timeunit 1ns;
  timeprecision 1ps;
  import cscm_pkg::*;
  logic CLOCK_I = 0, RSTN_I = 0, RX_VALID_I, TX_READY_I, TX_VALID_O;
  logic PAR_MASTER_I = 0, SECONDARY_OUTPUT_GOOD_I = 0, PRIMARY_STAGE_GOOD_I = 0;
  logic DUMMY_LOAD_ACTIVE_I = 0, INIT_DONE_I = 0, NVM_ACCESS_ERROR_I = 0;
  logic BIDIR_STORED_I = 0, OP_STORED_I = 1, LOCAL_ON_I = 0, DIR_CTRL_I = 1;
  logic OUTPUT_ON_O, SHUTDOWN_O, LED_ON_O, CAN_CTRL_O, BATTERY_MODE_O;
  logic DIR_CTRL_EFF_O;
  logic [2:0]  UNIT_ADDR_I = 3'h5, CFG_STORED_I = 3'h1;
  logic [28:0] RX_ID_I, TX_ID_O;
  logic [3:0]  RX_DLC_I, TX_DLC_O, dlc;
  logic [63:0] RX_DATA_I, TX_DATA_O, d;
  logic [23:0] SCALE_CODES_I = 24'h0;
  logic [15:0] LOCAL_ADJUSTER_VOUT_I = 16'h1234, LOCAL_ADJUSTER_IOUT_I = 16'h0;
  logic [15:0] CD_CTRL_I = 16'hbeef, VOUT_TARGET_O, IOUT_TARGET_O, CD_CTRL_EFF_O;
  int n_fail = 0, checks = 0;
  initial forever #4 CLOCK_I = ~CLOCK_I;
  cscm_status_config u_cscm_status_config (.CLOCK_I, .RSTN_I, .UNIT_ADDR_I,
    .RX_VALID_I, .RX_ID_I, .RX_DLC_I, .RX_DATA_I, .TX_READY_I, .PAR_MASTER_I,
    .SECONDARY_OUTPUT_GOOD_I, .PRIMARY_STAGE_GOOD_I, .DUMMY_LOAD_ACTIVE_I,
    .INIT_DONE_I, .NVM_ACCESS_ERROR_I, .SCALE_CODES_I, .CFG_STORED_I,
    .BIDIR_STORED_I, .OP_STORED_I, .LOCAL_ADJUSTER_VOUT_I, .LOCAL_ADJUSTER_IOUT_I,
    .LOCAL_ON_I, .DIR_CTRL_I, .CD_CTRL_I, .TX_VALID_O, .TX_ID_O, .TX_DLC_O,
    .TX_DATA_O, .VOUT_TARGET_O, .IOUT_TARGET_O, .OUTPUT_ON_O, .SHUTDOWN_O,
    .LED_ON_O, .CAN_CTRL_O, .BATTERY_MODE_O, .DIR_CTRL_EFF_O, .CD_CTRL_EFF_O);
  cscm_ctrl_model u_cscm_ctrl_model (.clk_i(CLOCK_I), .tx_valid_i(TX_VALID_O),
    .tx_id_i(TX_ID_O), .tx_dlc_i(TX_DLC_O), .tx_data_i(TX_DATA_O),
    .tx_ready_o(TX_READY_I), .rx_valid_o(RX_VALID_I), .rx_id_o(RX_ID_I),
    .rx_dlc_o(RX_DLC_I), .rx_data_o(RX_DATA_I));
  task automatic chk(input logic [63:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] c, v);
    u_cscm_ctrl_model.send({ID_RX_HI, a}, DLC_WRITE, {32'h0, v, c});
    repeat (4) @(negedge CLOCK_I);
  endtask
  // Reads wait for the answer, so the sender is idle for the next one
  task automatic rd(input logic [7:0] a, input logic [15:0] c);
    int n0;
    n0 = u_cscm_ctrl_model.n_got;
    u_cscm_ctrl_model.send({ID_RX_HI, a}, DLC_READ, {48'h0, c});
    repeat (40) if (u_cscm_ctrl_model.n_got == n0) @(negedge CLOCK_I);
    chk(u_cscm_ctrl_model.n_got - n0, (a == 8'hff) ? 0 : 1, "answers");
    d = u_cscm_ctrl_model.got_data;
    dlc = u_cscm_ctrl_model.got_dlc;
    if (a != 8'hff) chk(u_cscm_ctrl_model.got_id, {ID_TX_HI, 5'h0, UNIT_ADDR_I}, "id");
  endtask
  task automatic t_preset;
    for (int p = 0; p < 4; p++) begin
      CFG_STORED_I = {p[1:0], 1'b1};
      RSTN_I = 1'b0;
      repeat (3) @(negedge CLOCK_I);
      RSTN_I = 1'b1;
      repeat (6) @(negedge CLOCK_I);
      chk(OUTPUT_ON_O, p == 1 || p == 2, "power-up on/off");
      chk(CAN_CTRL_O, 1, "stored control source");
    end
    $display("preset test done");
  endtask
  task automatic t_status;
    for (int i = 0; i < 2; i++) begin
      {NVM_ACCESS_ERROR_I, INIT_DONE_I, DUMMY_LOAD_ACTIVE_I, PRIMARY_STAGE_GOOD_I,
       SECONDARY_OUTPUT_GOOD_I, PAR_MASTER_I} = i ? 6'h15 : 6'h2a;
      repeat (3) @(negedge CLOCK_I);
      rd({5'h0, UNIT_ADDR_I}, CMD_STATUS);
      chk(dlc, 4'h4, "status length");
      chk(d, {32'h0, i ? 16'h0025 : 16'h0052, CMD_STATUS}, "status");
    end
    NVM_ACCESS_ERROR_I = 1'b0;
    $display("status test done");
  endtask
  task automatic t_scale;
    u_cscm_ctrl_model.stall = 0;
    for (int i = 0; i < 2; i++) begin
      SCALE_CODES_I = i ? 24'h468900 : 24'ha94075;
      repeat (3) @(negedge CLOCK_I);
      rd({5'h0, UNIT_ADDR_I}, CMD_SCALING);
      chk(dlc, 4'h8, "scaling length");
      chk(d, {16'h0, i ? 32'h04068900 : 32'h00094075, CMD_SCALING}, "codes");
    end
    u_cscm_ctrl_model.stall = 5;
    $display("scaling test done");
  endtask
  task automatic t_config;
    wr({5'h0, UNIT_ADDR_I}, CMD_CONFIG, 16'hfff9);
    rd({5'h0, UNIT_ADDR_I}, CMD_CONFIG);
    chk(d, {32'h0, 16'h0001, CMD_CONFIG}, "config undefined bits");
    wr({5'h0, UNIT_ADDR_I}, CMD_OUTPUT_VOLTAGE_SETPOINT, 16'h0bb8);
    wr({5'h0, UNIT_ADDR_I}, CMD_OUTPUT_CURRENT_SETPOINT, 16'h0960);
    wr({5'h0, UNIT_ADDR_I}, CMD_OPERATION, 16'h0001);
    chk(VOUT_TARGET_O, 16'h0bb8, "remote setpoint");
    chk(IOUT_TARGET_O, 16'h0960, "remote current");
    chk(OUTPUT_ON_O, 1, "remote on");
    // Values above one are not a legal on/off command
    wr({5'h0, UNIT_ADDR_I}, CMD_OPERATION, 16'h0100);
    chk(OUTPUT_ON_O, 1, "bad on/off value ignored");
    rd({5'h0, UNIT_ADDR_I}, CMD_OPERATION);
    chk(dlc, 4'h3, "operation length");
    chk(d, {40'h0, OP_ON, CMD_OPERATION}, "operation read");
    wr({5'h0, UNIT_ADDR_I - 3'h1}, CMD_CONFIG, 16'h0000);
    chk(CAN_CTRL_O, 1, "other unit ignored");
    wr({5'h0, UNIT_ADDR_I}, CMD_CONFIG, 16'h0000);
    chk({VOUT_TARGET_O, IOUT_TARGET_O, OUTPUT_ON_O}, {LOCAL_ADJUSTER_VOUT_I,
         LOCAL_ADJUSTER_IOUT_I, LOCAL_ON_I}, "local");
    wr(BCAST_ADDR, CMD_CONFIG, 16'h0001);
    chk(CAN_CTRL_O, 1, "broadcast write");
    rd(BCAST_ADDR, CMD_CONFIG);
    $display("config test done");
  endtask
  task automatic t_bidir;
    wr({5'h0, UNIT_ADDR_I}, CMD_BIDIR, 16'hffff);
    chk({BATTERY_MODE_O, DIR_CTRL_EFF_O, CD_CTRL_EFF_O}, {2'h3, CD_CTRL_I}, "battery");
    wr({5'h0, UNIT_ADDR_I}, CMD_BIDIR, 16'h0000);
    chk({BATTERY_MODE_O, DIR_CTRL_EFF_O, CD_CTRL_EFF_O}, 0, "auto-detect");
    $display("bidirectional test done");
  endtask
  task automatic t_nvm;
    NVM_ACCESS_ERROR_I = 1'b1;
    repeat (3) @(negedge CLOCK_I);
    chk({SHUTDOWN_O, LED_ON_O, OUTPUT_ON_O}, 3'h4, "memory error off");
    NVM_ACCESS_ERROR_I = 1'b0;
    repeat (3) @(negedge CLOCK_I);
    chk({SHUTDOWN_O, LED_ON_O, OUTPUT_ON_O}, 3'h3, "recovered");
    $display("memory error test done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end
  initial begin
    t_preset();
    t_status();
    t_scale();
    t_config();
    t_bidir();
    t_nvm();
    print_verdict();
  end
endmodule // tb_cscm_status_config
